//--- rtl/lrmsm_regs.svh
// constants for the raw mii indicator output mux
`ifndef LRMSM_REGS_SVH
`define LRMSM_REGS_SVH

`define LRMSM_FUN_W 2
`define LRMSM_FUN_RAW 2'h3
`define LRMSM_PIN_N 6
`define LRMSM_PIN_P0_TXEN 5
`define LRMSM_PIN_P2_TXEN 4
`define LRMSM_PIN_P2_RXDV 3
`define LRMSM_PIN_P0_RXDV 2
`define LRMSM_PIN_P1_TXEN 1
`define LRMSM_PIN_P1_RXDV 0
`define LRMSM_PINS_RST 6'h00

`endif

//--- rtl/lrmsm_pkg.sv
// types for the raw mii indicator output mux
package lrmsm_pkg;
   typedef struct packed {
      logic tx_en;
      logic rx_dv;
   } lrmsm_mii_t;

   typedef struct packed {
      logic [5:0] level;
      logic [5:0] drive_en;
      logic [5:0] inbuf_en;
      logic [5:0] pullup_en;
   } lrmsm_pins_t;
endpackage

//--- rtl/lrmsm_mux.sv
// raw mii signal mux onto the six shared indicator pins
`include "lrmsm_regs.svh"
module lrmsm_mux
#(
   parameter int PIN_N = `LRMSM_PIN_N,
   parameter int FUN_W = `LRMSM_FUN_W
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [1:0] led_fun,
   input wire lrmsm_pkg::lrmsm_mii_t port0_mii,
   input wire lrmsm_pkg::lrmsm_mii_t port1_mii,
   input wire lrmsm_pkg::lrmsm_mii_t port2_mii,
   output lrmsm_pkg::lrmsm_pins_t pins
);
   import lrmsm_pkg::*;

   localparam logic [5:0] PINS_RST = `LRMSM_PINS_RST;
   localparam logic [5:0] MAP_ALL = 6'h3F;

   // pin positions of the raw-mode sources
   localparam int unsigned PIN_P0_TX = `LRMSM_PIN_P0_TXEN;
   localparam int unsigned PIN_P2_TX = `LRMSM_PIN_P2_TXEN;
   localparam int unsigned PIN_P2_RX = `LRMSM_PIN_P2_RXDV;
   localparam int unsigned PIN_P0_RX = `LRMSM_PIN_P0_RXDV;
   localparam int unsigned PIN_P1_TX = `LRMSM_PIN_P1_TXEN;
   localparam int unsigned PIN_P1_RX = `LRMSM_PIN_P1_RXDV;

   // ports and pin map are built for six pins and a two-bit field
   generate
      if (PIN_N != 6)
      begin : g_bad_pin_n
         $error("lrmsm_mux: PIN_N must be 6");
      end
      if (FUN_W != 2)
      begin : g_bad_fun_w
         $error("lrmsm_mux: FUN_W must be 2");
      end
      if (((6'h01 << PIN_P0_TX) | (6'h01 << PIN_P2_TX)
         | (6'h01 << PIN_P2_RX) | (6'h01 << PIN_P0_RX)
         | (6'h01 << PIN_P1_TX) | (6'h01 << PIN_P1_RX))
         != MAP_ALL)
      begin : g_bad_map
         $error("lrmsm_mux: pin map must cover every pin once");
      end
   endgenerate

   // true for the raw-signal function code
   function automatic logic fun_is_raw
   (
      input logic [1:0] fun
   );
      fun_is_raw = (fun == `LRMSM_FUN_RAW);
   endfunction

   // source signal behind one pin in raw mode
   function automatic logic pin_source
   (
      input int unsigned pin,
      input logic p0_tx,
      input logic p0_rx,
      input logic p1_tx,
      input logic p1_rx,
      input logic p2_tx,
      input logic p2_rx
   );
      logic bit_v;
      bit_v = 1'b0;
      case (pin)
         PIN_P0_TX: bit_v = p0_tx;
         PIN_P2_TX: bit_v = p2_tx;
         PIN_P2_RX: bit_v = p2_rx;
         PIN_P0_RX: bit_v = p0_rx;
         PIN_P1_TX: bit_v = p1_tx;
         PIN_P1_RX: bit_v = p1_rx;
         default: bit_v = 1'b0;
      endcase
      pin_source = bit_v;
   endfunction

   wire p0_tx;
   wire p0_rx;
   wire p1_tx;
   wire p1_rx;
   wire p2_tx;
   wire p2_rx;
   wire raw_mode;
   wire raw_drive;
   wire [5:0] src;
   wire [5:0] level_next;
   wire [5:0] drive_next;
   wire [5:0] inbuf_next;
   wire [5:0] pullup_next;
   wire [5:0] level_q;
   wire [5:0] drive_q;
   wire [5:0] inbuf_q;
   wire [5:0] pullup_q;
   lrmsm_pins_t pins_q;

   // no link input reaches the mux
   assign p0_tx = port0_mii.tx_en;
   assign p0_rx = port0_mii.rx_dv;
   assign p1_tx = port1_mii.tx_en;
   assign p1_rx = port1_mii.rx_dv;
   assign p2_tx = port2_mii.tx_en;
   assign p2_rx = port2_mii.rx_dv;

   assign raw_mode = fun_is_raw(led_fun);
   assign raw_drive = fun_is_raw(led_fun);

   // level path, one flop per pin
   generate
      for (genvar lvl_i = 0; lvl_i < PIN_N; lvl_i++)
      begin : g_level
         logic level_reg;

         assign src[lvl_i] = pin_source(lvl_i, p0_tx, p0_rx,
            p1_tx, p1_rx, p2_tx, p2_rx);
         // straps never reach here, the source goes out as is
         assign level_next[lvl_i] = raw_mode ? src[lvl_i]
            : PINS_RST[lvl_i];

         always_ff @(posedge clk_sys or negedge rst_n)
         begin
            if (!rst_n)
            begin
               level_reg <= PINS_RST[lvl_i];
            end
            else if (clk_en)
            begin
               level_reg <= level_next[lvl_i];
            end
         end

         assign level_q[lvl_i] = level_reg;
      end
   endgenerate

   // push-pull drive, released outside raw mode
   generate
      for (genvar drv_i = 0; drv_i < PIN_N; drv_i++)
      begin : g_drive
         logic drive_reg;

         assign drive_next[drv_i] = raw_drive;

         always_ff @(posedge clk_sys or negedge rst_n)
         begin
            if (!rst_n)
            begin
               drive_reg <= 1'b0;
            end
            else if (clk_en)
            begin
               drive_reg <= drive_next[drv_i];
            end
         end

         assign drive_q[drv_i] = drive_reg;
      end
   endgenerate

   // input buffers stay off in every mode
   generate
      for (genvar buf_i = 0; buf_i < PIN_N; buf_i++)
      begin : g_inbuf
         logic inbuf_reg;

         assign inbuf_next[buf_i] = 1'b0;

         always_ff @(posedge clk_sys or negedge rst_n)
         begin
            if (!rst_n)
            begin
               inbuf_reg <= 1'b0;
            end
            else if (clk_en)
            begin
               inbuf_reg <= inbuf_next[buf_i];
            end
         end

         assign inbuf_q[buf_i] = inbuf_reg;
      end
   endgenerate

   // pull-ups stay off in every mode
   generate
      for (genvar pu_i = 0; pu_i < PIN_N; pu_i++)
      begin : g_pullup
         logic pullup_reg;

         assign pullup_next[pu_i] = 1'b0;

         always_ff @(posedge clk_sys or negedge rst_n)
         begin
            if (!rst_n)
            begin
               pullup_reg <= 1'b0;
            end
            else if (clk_en)
            begin
               pullup_reg <= pullup_next[pu_i];
            end
         end

         assign pullup_q[pu_i] = pullup_reg;
      end
   endgenerate

   // outputs come straight from the pin flops
   assign pins_q.level = level_q;
   assign pins_q.drive_en = drive_q;
   assign pins_q.inbuf_en = inbuf_q;
   assign pins_q.pullup_en = pullup_q;

   assign pins = pins_q;
endmodule

//--- dv/lrmsm_mux_assertions.sv
// port checker for the raw mii indicator mux
module lrmsm_chk
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [1:0] led_fun,
   input wire lrmsm_pkg::lrmsm_mii_t port0_mii,
   input wire lrmsm_pkg::lrmsm_mii_t port1_mii,
   input wire lrmsm_pkg::lrmsm_mii_t port2_mii,
   input wire lrmsm_pkg::lrmsm_pins_t pins
);
   wire raw_sel;
   wire [5:0] map_src;

   assign raw_sel = (led_fun == 2'h3);
   assign map_src = {port0_mii.tx_en, port2_mii.tx_en, port2_mii.rx_dv,
      port0_mii.rx_dv, port1_mii.tx_en, port1_mii.rx_dv};

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   a_raw_level: assert property (
      clk_en && raw_sel |=> pins.level == $past(map_src))
      else $error("raw level differs from pin map");
   a_off_level: assert property (
      clk_en && !raw_sel |=> pins.level == 6'h00)
      else $error("level driven outside raw mode");
   a_raw_drive: assert property (
      clk_en && raw_sel |=> pins.drive_en == 6'h3F)
      else $error("pin not push-pull in raw mode");
   a_off_drive: assert property (
      clk_en && !raw_sel |=> pins.drive_en == 6'h00)
      else $error("pin driven outside raw mode");
   a_bufs_off: assert property (
      pins.inbuf_en == 6'h00 && pins.pullup_en == 6'h00)
      else $error("input buffer or pull-up on");
   a_frozen_pins: assert property (
      !clk_en |=> $stable(pins))
      else $error("pins moved with clock enable low");
   a_tx0_follow: assert property (
      clk_en && raw_sel && port0_mii.tx_en |=> pins.level[5])
      else $error("port 0 transmit not shown");
   a_rx0_follow: assert property (
      clk_en && raw_sel && !port0_mii.rx_dv |=> !pins.level[2])
      else $error("port 0 receive not shown");
endmodule

bind lrmsm_mux lrmsm_chk i_lrmsm_chk
(
   .clk_sys(clk_sys),
   .rst_n(rst_n),
   .clk_en(clk_en),
   .led_fun(led_fun),
   .port0_mii(port0_mii),
   .port1_mii(port1_mii),
   .port2_mii(port2_mii),
   .pins(pins)
);

//--- dv/lrmsm_pads.sv
// board pads watching the pins, pulled high when released
module lrmsm_pads
(
   input wire lrmsm_pkg::lrmsm_pins_t pins,
   output logic [5:0] pad
);
   // a released pin floats to its pull-up
   assign pad = pins.level | ~pins.drive_en;
endmodule

//--- dv/lrmsm_mux_test.sv
// self-checking bench for the raw mii indicator mux
module lrmsm_mux_test;
   timeunit 1ns;
   timeprecision 1ps;
   import lrmsm_pkg::*;

   localparam int WDOG_CYC = 2000;
   localparam int RAND_N = 400;

   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en = 1'b0;
   logic [1:0] led_fun = 2'h0;
   lrmsm_mii_t p0 = '0;
   lrmsm_mii_t p1 = '0;
   lrmsm_mii_t p2 = '0;
   lrmsm_pins_t pins;
   logic [5:0] pad;
   logic [5:0] exp_level = 6'h00;
   logic [5:0] exp_drive = 6'h00;
   logic [5:0] walk;
   logic [31:0] rnd;
   int error_cnt = 0;
   int checks = 0;

   always #5 clk_sys = ~clk_sys;

   lrmsm_mux i_lrmsm_mux
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .led_fun(led_fun),
      .port0_mii(p0),
      .port1_mii(p1),
      .port2_mii(p2),
      .pins(pins)
   );

   lrmsm_pads i_lrmsm_pads
   (
      .pins(pins),
      .pad(pad)
   );

   // raw-mode pin levels from the three ports
   function automatic logic [5:0] raw_map
   (
      input lrmsm_mii_t a,
      input lrmsm_mii_t b,
      input lrmsm_mii_t c
   );
      raw_map = {a.tx_en, c.tx_en, c.rx_dv, a.rx_dv, b.tx_en, b.rx_dv};
   endfunction

   // what the board sees: released pins read high
   function automatic logic [5:0] exp_pad_of
   (
      input logic [5:0] level,
      input logic [5:0] drive
   );
      exp_pad_of = level | ~drive;
   endfunction

   task automatic chk
   (
      input logic [5:0] seen,
      input logic [5:0] expd,
      input string what
   );
      checks++;
      if (seen !== expd)
      begin
         error_cnt++;
         $display("MISMATCH %0t %s", $time, what);
      end
   endtask

   task automatic summarize;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
      begin
         $display("Test passed");
      end
      else
      begin
         $display("Test failed");
      end
      $finish;
   endtask

   // drive at a falling edge, check at the next one
   task automatic step
   (
      input logic en,
      input logic [1:0] fun,
      input lrmsm_mii_t a,
      input lrmsm_mii_t b,
      input lrmsm_mii_t c
   );
      clk_en = en;
      led_fun = fun;
      p0 = a;
      p1 = b;
      p2 = c;
      if (en)
      begin
         exp_level = (fun == 2'h3) ? raw_map(a, b, c) : 6'h00;
         exp_drive = (fun == 2'h3) ? 6'h3F : 6'h00;
      end
      @(negedge clk_sys);
      chk(pins.level, exp_level, "level");
      chk(pins.drive_en, exp_drive, "drive");
      chk(pins.inbuf_en, 6'h00, "input buffer");
      chk(pins.pullup_en, 6'h00, "pull-up");
      chk(pad, exp_pad_of(exp_level, exp_drive), "pad");
   endtask

   initial
   begin
      repeat (WDOG_CYC) @(posedge clk_sys);
      error_cnt++;
      $display("MISMATCH %0t watchdog expired", $time);
      summarize;
   end

   initial
   begin
      void'($urandom(32'hBC5A9E36));
      repeat (4) @(negedge clk_sys);
      chk(pad, 6'h3F, "pad in reset");
      chk(pins.level, 6'h00, "level in reset");
      rst_n = 1'b1;
      for (int j = 0; j < 6; j++)
      begin
         walk = 6'h01 << j;
         step(1'b1, 2'h3, walk[1:0], walk[3:2], walk[5:4]);
      end
      for (int f = 0; f < 4; f++)
      begin
         step(1'b1, f[1:0], 2'h3, 2'h3, 2'h3);
      end
      step(1'b1, 2'h3, 2'h3, 2'h3, 2'h3);
      step(1'b0, 2'h3, 2'h0, 2'h0, 2'h0);
      step(1'b0, 2'h0, 2'h0, 2'h0, 2'h0);
      $display("corner test done");
      for (int i = 0; i < RAND_N; i++)
      begin
         rnd = $urandom;
         step(rnd[0], rnd[9] ? 2'h3 : rnd[2:1],
            rnd[4:3], rnd[6:5], rnd[8:7]);
      end
      $display("random test done");
      rst_n = 1'b0;
      exp_level = 6'h00;
      exp_drive = 6'h00;
      clk_en = 1'b1;
      led_fun = 2'h3;
      p0 = 2'h3;
      @(negedge clk_sys);
      chk(pad, 6'h3F, "pad in mid reset");
      chk(pins.level, 6'h00, "level in mid reset");
      rst_n = 1'b1;
      step(1'b1, 2'h3, 2'h2, 2'h1, 2'h3);
      step(1'b1, 2'h3, 2'h1, 2'h2, 2'h0);
      $display("reset test done");
      summarize;
   end
endmodule
